// ---- include/mic_detect_defines.vh ----
`ifndef MIC_DETECT_DEFINES_VH
`define MIC_DETECT_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFF_CONTROL        12'h000
`define OFF_STATE          12'h004
`define OFF_IRQ_STATUS     12'h008
`define OFF_IRQ_CLEAR      12'h00C
`define OFF_IRQ_ENABLE     12'h010

// ****************************************
// control field positions
// ****************************************
`define CTL_ENABLE_BIT     0
`define CTL_HOOK_THR_LO    2
`define CTL_HOOK_THR_HI    3
`define CTL_INS_THR_LO     4
`define CTL_INS_THR_HI     6
`define CTL_INS_POL_BIT    8
`define CTL_HOOK_POL_BIT   9

// ****************************************
// event bit positions (status, clear, enable)
// ****************************************
`define EVT_INS_BIT        0
`define EVT_HOOK_BIT       1
`define EVT_WIDTH          2

// ****************************************
// reset values
// ****************************************
`define RST_INS_THR        3'h0
`define RST_HOOK_THR       2'h0
`define RST_EVT            2'h0

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS      10
`define MEAS_PERIOD_NS     10000
`define MEAS_CYCLES        ((`MEAS_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOOK_COUNT         10
`define DET_COUNT          4

`endif

// ---- logic/consecutive_filter.v ----
`timescale 1ns/100ps

// ****************************************
// hysteresis state with n-in-a-row qualification
// ****************************************
module consecutive_filter
#(
  parameter COUNT = 10,                  // consecutive measurements needed
  parameter CW    = 4                    // counter width
)
(
  input  wire pclk,                      // system clock
  input  wire presetn,                   // async reset, active low
  input  wire run,                       // detection enabled
  input  wire tick,                      // one measurement this cycle
  input  wire cond_set,                  // above upper threshold
  input  wire cond_clear,                // below lower threshold
  output wire state_out                  // qualified state
);

  localparam [CW-1:0] LAST = COUNT[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}; // last count value

  reg          state_reg;                // qualified state
  reg [CW-1:0] cnt_reg;                  // consecutive pass count

  assign state_out = state_reg;

  // qualify transitions over consecutive samples
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= 1'b0;
      cnt_reg   <= {CW{1'b0}};
    end
    else if (!run)
    begin
      // disabled: forget state and progress
      state_reg <= 1'b0;
      cnt_reg   <= {CW{1'b0}};
    end
    else if (tick)
    begin
      // upper level to assert, lower level to release
      if ((!state_reg && cond_set) || (state_reg && cond_clear)) // R1
      begin
        if (cnt_reg == LAST) // R2
        begin
          state_reg <= ~state_reg;
          cnt_reg   <= {CW{1'b0}};
        end
        else
        begin
          cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
        end
      end
      else
      begin
        // failing sample restarts the run
        cnt_reg <= {CW{1'b0}}; // R2 R14
      end
    end
  end

endmodule // consecutive_filter

// ---- logic/mic_current_detect_filter.v ----
// Functional notes
// R1 - separate assert and release current levels
// R2 - hookswitch needs ten consecutive passing measurements
// R3 - insertion when current exceeds insertion threshold
// R4 - polarity zero: insertion sets insertion status
// R5 - polarity one: removal sets insertion status
// R6 - insertion filtered, reported within detect delay
// R7 - host waits out bounce before polarity change
// R8 - state outputs share the same delay
// R9 - hookswitch when current exceeds hookswitch threshold
// R10 - polarity zero: press sets hookswitch status
// R11 - polarity one: release sets hookswitch status
// R12 - host provides clock, enable, dc servo
// R13 - events during clock loss reported later
// R14 - filter rejects short noise spikes
// R15 - detection only while current detect enabled
// R16 - three-bit insertion, two-bit hookswitch threshold fields
// R17 - sticky status bits feed interrupt output
// R18 - one sample per measurement period
`timescale 1ns/100ps
`include "mic_detect_defines.vh"

module mic_current_detect_filter
#(
  parameter MEAS_CYCLES = `MEAS_CYCLES,  // clocks per measurement
  parameter MW          = 16,            // measurement counter width
  parameter HOOK_COUNT  = `HOOK_COUNT,   // hookswitch qualification count
  parameter DET_COUNT   = `DET_COUNT,    // insertion qualification count
  parameter FCW         = 4              // filter counter width
)
(
  input  wire        pclk,                          // apb and system clock
  input  wire        presetn,                       // async reset, active low
  input  wire [11:0] paddr,                         // apb byte address
  input  wire        psel,                          // apb select
  input  wire        penable,                       // apb access phase
  input  wire        pwrite,                        // apb write
  input  wire [31:0] pwdata,                        // apb write data
  input  wire [3:0]  pstrb,                         // apb byte strobes
  output reg  [31:0] prdata,                        // apb read data
  output reg         pready,                        // apb ready
  output reg         pslverr,                       // apb error
  input  wire        ins_above_upper,               // above insertion level
  input  wire        ins_above_lower,               // above removal level
  input  wire        hook_above_upper,              // above press level
  input  wire        hook_above_lower,              // above release level
  input  wire        master_clock_present,          // master clock running
  input  wire        frequency_locked_loop_free_run,// loop free-running as source
  input  wire        system_clock_enable,           // system clock enabled
  input  wire [3:0]  dc_servo_channel_enable,       // dc servo channels
  output reg  [2:0]  insertion_current_threshold,   // to insertion comparator
  output reg  [1:0]  hookswitch_current_threshold,  // to hookswitch comparator
  output reg         current_detect_enable,         // to comparator bias
  output reg         ins_state_out,                 // filtered insertion state
  output reg         hook_state_out,                // filtered hookswitch state
  output reg         irq                            // level interrupt
);

  // ****************************************
  // declarations
  // ****************************************
  localparam [MW-1:0] MEAS_LAST = MEAS_CYCLES[MW-1:0] - {{(MW-1){1'b0}}, 1'b1}; // divider wrap

  reg  [MW-1:0]         meas_cnt_reg;       // measurement divider
  reg                   ins_pol_reg;        // insertion event polarity
  reg                   hook_pol_reg;       // hookswitch event polarity
  reg  [`EVT_WIDTH-1:0] status_reg;         // sticky event status
  reg  [`EVT_WIDTH-1:0] status_next;        // next sticky status
  reg  [`EVT_WIDTH-1:0] irq_en_reg;         // interrupt enable
  reg                   ins_prev_reg;       // last insertion state
  reg                   hook_prev_reg;      // last hookswitch state
  reg  [31:0]           rdata_next;         // read mux
  reg                   rerr_next;          // unmapped read or write
  reg  [`EVT_WIDTH-1:0] clear_next;         // clear request this cycle
  reg  [`EVT_WIDTH-1:0] set_next;           // events this cycle
  wire                  clock_ok;           // clocking criteria met
  wire                  meas_tick;          // one measurement
  wire                  ins_state;          // filtered insertion
  wire                  hook_state;         // filtered hookswitch
  wire                  access;             // apb access phase
  wire                  wr_cycle;           // completing write
  wire                  ins_rise;           // insertion detected
  wire                  ins_fall;           // removal detected
  wire                  hook_rise;          // press detected
  wire                  hook_fall;          // release detected

  // ****************************************
  // clocking criteria and measurement rate
  // ****************************************

  // clock source, system enable and one servo channel
  assign clock_ok = (master_clock_present | frequency_locked_loop_free_run) &
                    system_clock_enable & (|dc_servo_channel_enable); // R12

  // tick only while measurements can run
  assign meas_tick = clock_ok && (meas_cnt_reg == MEAS_LAST); // R18

  // measurement divider, cleared while clocking is unmet or detection is off
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meas_cnt_reg <= {MW{1'b0}};
    end
    else if (!clock_ok || !current_detect_enable)
    begin
      // restart from zero, comparator levels keep pending events
      meas_cnt_reg <= {MW{1'b0}}; // R13
    end
    else if (meas_cnt_reg == MEAS_LAST)
    begin
      meas_cnt_reg <= {MW{1'b0}}; // R18
    end
    else
    begin
      meas_cnt_reg <= meas_cnt_reg + {{(MW-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // filters
  // ****************************************

  // insertion: band-limited over a few samples
  consecutive_filter
  #(
    .COUNT (DET_COUNT),
    .CW    (FCW)
  )
  u_ins_filter
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (current_detect_enable),
    .tick       (meas_tick),
    .cond_set   (ins_above_upper),
    .cond_clear (~ins_above_lower),
    .state_out  (ins_state)
  ); // R3 R6 R15

  // hookswitch: ten in a row
  consecutive_filter
  #(
    .COUNT (HOOK_COUNT),
    .CW    (FCW)
  )
  u_hook_filter
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (current_detect_enable),
    .tick       (meas_tick),
    .cond_set   (hook_above_upper),
    .cond_clear (~hook_above_lower),
    .state_out  (hook_state)
  ); // R2 R9 R15

  // ****************************************
  // event detection
  // ****************************************

  // edges of filtered states, only while enabled
  assign ins_rise  = current_detect_enable & ins_state & ~ins_prev_reg;   // R3
  assign ins_fall  = current_detect_enable & ~ins_state & ins_prev_reg;
  assign hook_rise = current_detect_enable & hook_state & ~hook_prev_reg; // R9
  assign hook_fall = current_detect_enable & ~hook_state & hook_prev_reg;

  // previous states and mirrored state outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ins_prev_reg   <= 1'b0;
      hook_prev_reg  <= 1'b0;
      ins_state_out  <= 1'b0;
      hook_state_out <= 1'b0;
    end
    else
    begin
      ins_prev_reg   <= ins_state;
      hook_prev_reg  <= hook_state;
      // same filtered timing as the events
      ins_state_out  <= ins_state;  // R8
      hook_state_out <= hook_state; // R8
    end
  end

  // select edge by polarity
  always @*
  begin
    set_next = `RST_EVT;
    // insertion event: rise at polarity 0, fall at 1
    if (ins_pol_reg)
    begin
      set_next[`EVT_INS_BIT] = ins_fall; // R5
    end
    else
    begin
      set_next[`EVT_INS_BIT] = ins_rise; // R4
    end
    // hookswitch event: press at polarity 0, release at 1
    if (hook_pol_reg)
    begin
      set_next[`EVT_HOOK_BIT] = hook_fall; // R11
    end
    else
    begin
      set_next[`EVT_HOOK_BIT] = hook_rise; // R10
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  assign access   = psel & penable & ~pready;
  // a write commits at the edge where the master sees pready high
  assign wr_cycle = psel & penable & pready & pwrite;

  // read mux and decode error
  always @*
  begin
    rdata_next = 32'h00000000;
    rerr_next  = 1'b0;
    case (paddr)
      `OFF_CONTROL:
      begin
        rdata_next[`CTL_ENABLE_BIT]                   = current_detect_enable;
        rdata_next[`CTL_HOOK_THR_HI:`CTL_HOOK_THR_LO] = hookswitch_current_threshold;
        rdata_next[`CTL_INS_THR_HI:`CTL_INS_THR_LO]   = insertion_current_threshold;
        rdata_next[`CTL_INS_POL_BIT]                  = ins_pol_reg;
        rdata_next[`CTL_HOOK_POL_BIT]                 = hook_pol_reg;
      end
      `OFF_STATE:
      begin
        // live filtered state and clocking
        rdata_next[0] = ins_state;
        rdata_next[1] = hook_state;
        rdata_next[2] = clock_ok;
      end
      `OFF_IRQ_STATUS:
      begin
        rdata_next[`EVT_WIDTH-1:0] = status_reg;
      end
      `OFF_IRQ_CLEAR:
      begin
        // write-only, reads zero
        rdata_next = 32'h00000000;
      end
      `OFF_IRQ_ENABLE:
      begin
        rdata_next[`EVT_WIDTH-1:0] = irq_en_reg;
      end
      default:
      begin
        // unmapped address
        rerr_next = 1'b1;
      end
    endcase
  end

  // one wait state, registered answer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else if (access)
    begin
      pready  <= 1'b1;
      pslverr <= rerr_next;
      prdata  <= pwrite ? 32'h00000000 : rdata_next;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // control register writes, lane by lane
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      current_detect_enable        <= 1'b0;
      insertion_current_threshold  <= `RST_INS_THR;
      hookswitch_current_threshold <= `RST_HOOK_THR;
      ins_pol_reg                  <= 1'b0;
      hook_pol_reg                 <= 1'b0;
      irq_en_reg                   <= `RST_EVT;
    end
    else if (wr_cycle && (paddr == `OFF_CONTROL))
    begin
      if (pstrb[0])
      begin
        current_detect_enable        <= pwdata[`CTL_ENABLE_BIT];                   // R15
        hookswitch_current_threshold <= pwdata[`CTL_HOOK_THR_HI:`CTL_HOOK_THR_LO]; // R16
        insertion_current_threshold  <= pwdata[`CTL_INS_THR_HI:`CTL_INS_THR_LO];   // R16
      end
      if (pstrb[1])
      begin
        ins_pol_reg  <= pwdata[`CTL_INS_POL_BIT];
        hook_pol_reg <= pwdata[`CTL_HOOK_POL_BIT];
      end
    end
    else if (wr_cycle && (paddr == `OFF_IRQ_ENABLE) && pstrb[0])
    begin
      irq_en_reg <= pwdata[`EVT_WIDTH-1:0];
    end
  end

  // ****************************************
  // interrupt status and output
  // ****************************************

  // write-one-to-clear request
  always @*
  begin
    clear_next = `RST_EVT;
    if (wr_cycle && (paddr == `OFF_IRQ_CLEAR) && pstrb[0])
    begin
      clear_next = pwdata[`EVT_WIDTH-1:0];
    end
    // set wins over a same-cycle clear
    status_next = (status_reg & ~clear_next) | set_next; // R17
  end

  // sticky status and level interrupt
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= `RST_EVT;
      irq        <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;                // R17
      irq        <= |(status_next & irq_en_reg); // R17
    end
  end

endmodule // mic_current_detect_filter

// ---- verif/mic_accessory_model.sv ----
`timescale 1ns/100ps

// ****************
// socket with comparators
// ****************
module mic_accessory_model
#(
  parameter HYST_UA = 16'h001E // release level below assert level
)
(
  input  wire [15:0] bias_ua,    // bias current, microamps
  input  wire [2:0]  ins_thr,    // insertion level select
  input  wire [1:0]  hook_thr,   // hookswitch level select
  input  wire        powered,    // detector on
  output wire        ins_upper,  // above insertion level
  output wire        ins_lower,  // above removal level
  output wire        hook_upper, // above press level
  output wire        hook_lower  // above release level
);
  wire [15:0] ins_lvl;  // insertion level
  wire [15:0] hook_lvl; // press level

  assign ins_lvl    = 16'h0046 + 16'h00BE * {13'h0000, ins_thr};
  assign hook_lvl   = 16'h0208 + 16'h0168 * {14'h0000, hook_thr};
  // unpowered comparators read low
  assign ins_upper  = powered & (bias_ua > ins_lvl);
  assign ins_lower  = powered & (bias_ua > ins_lvl - HYST_UA);
  assign hook_upper = powered & (bias_ua > hook_lvl);
  assign hook_lower = powered & (bias_ua > hook_lvl - HYST_UA);
endmodule // mic_accessory_model

// ---- verif/mic_detect_monitor.sv ----
`timescale 1ns/100ps

// ****************
// port checker
// ****************
module mic_detect_monitor
#(
  parameter MEAS_CYCLES = 1000, // clocks per measurement
  parameter HOOK_COUNT  = 10,   // hookswitch samples
  parameter DET_COUNT   = 4     // insertion samples
)
(
  input wire        pclk,                           // clock
  input wire        presetn,                        // reset, active low
  input wire        psel,                           // apb select
  input wire        penable,                        // apb access
  input wire [31:0] prdata,                         // apb read data
  input wire        pready,                         // apb ready
  input wire        pslverr,                        // apb error
  input wire        hook_above_upper,               // press comparator
  input wire        master_clock_present,           // master clock
  input wire        frequency_locked_loop_free_run, // loop clock
  input wire        system_clock_enable,            // clock enable
  input wire [3:0]  dc_servo_channel_enable,        // servo channels
  input wire        current_detect_enable,          // detect on
  input wire        ins_state_out,                  // insertion state
  input wire        hook_state_out,                 // hookswitch state
  input wire        irq                             // interrupt
);
  wire        clk_ok;  // clocking criteria met
  reg  [15:0] run_reg; // enabled cycles with clocks present

  assign clk_ok = (master_clock_present | frequency_locked_loop_free_run)
                  & system_clock_enable & (|dc_servo_channel_enable);

  // counts usable cycles, pauses while clocks are missing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_reg <= 16'h0000;
    else if (!current_detect_enable)
      run_reg <= 16'h0000;
    else if (clk_ok && run_reg != 16'hFFFF)
      run_reg <= run_reg + 16'h0001;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready_after_access;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_after_access: assert property (p_ready_after_access) else $error("ready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_err_with_ready;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("bad error reply");
  property p_irq_cause;
    $rose(irq) |-> $changed(ins_state_out) || $changed(hook_state_out) || $past(psel) || $past(psel, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_ins_min;
    $rose(ins_state_out) |-> run_reg >= DET_COUNT * MEAS_CYCLES;
  endproperty
  a_ins_min: assert property (p_ins_min) else $error("insertion too early");
  property p_hook_min;
    $rose(hook_state_out) |-> run_reg >= HOOK_COUNT * MEAS_CYCLES;
  endproperty
  a_hook_min: assert property (p_hook_min) else $error("hookswitch too early");
  property p_disable_clears;
    !current_detect_enable [*3] |-> !ins_state_out && !hook_state_out;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("state while off");
  property p_hook_needs_press;
    $rose(hook_state_out) |-> $past(hook_above_upper, 2) || $past(hook_above_upper, 3);
  endproperty
  a_hook_needs_press: assert property (p_hook_needs_press) else $error("press not seen");
endmodule // mic_detect_monitor

bind mic_current_detect_filter mic_detect_monitor #(.MEAS_CYCLES(MEAS_CYCLES), .HOOK_COUNT(HOOK_COUNT),
  .DET_COUNT(DET_COUNT)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .hook_above_upper(hook_above_upper),
  .master_clock_present(master_clock_present), .frequency_locked_loop_free_run(frequency_locked_loop_free_run),
  .system_clock_enable(system_clock_enable), .dc_servo_channel_enable(dc_servo_channel_enable),
  .current_detect_enable(current_detect_enable), .ins_state_out(ins_state_out),
  .hook_state_out(hook_state_out), .irq(irq));

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`include "mic_detect_defines.vh"

module tb;
  localparam MEAS = 4;  // short measurement period
  localparam DET  = 4;  // insertion samples
  localparam HOOK = 10; // hookswitch samples
  reg         pclk    = 1'b0;     // clock
  reg         presetn = 1'b0;     // reset
  reg  [11:0] paddr   = 12'h000;  // apb address
  reg         psel    = 1'b0;     // apb select
  reg         penable = 1'b0;     // apb access
  reg         pwrite  = 1'b0;     // apb direction
  reg  [31:0] pwdata  = 32'h0;    // apb data
  reg         mclk_on = 1'b1;     // master clock
  reg         fll_run = 1'b0;     // loop clock
  reg         sys_en  = 1'b1;     // clock enable
  reg  [3:0]  dcs     = 4'h1;     // servo channels
  reg  [15:0] bias    = 16'h0000; // bias current
  wire [31:0] prdata;
  wire        pready, pslverr, iau, ial, hau, hal, det_en, ins_st, hook_st, irq;
  wire [2:0]  ithr;
  wire [1:0]  hthr;
  int         bad_count = 0;
  int         check_count = 0;

  always #5 pclk = ~pclk;

  mic_current_detect_filter #(.MEAS_CYCLES(MEAS), .DET_COUNT(DET), .HOOK_COUNT(HOOK)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ins_above_upper(iau), .ins_above_lower(ial), .hook_above_upper(hau), .hook_above_lower(hal),
    .master_clock_present(mclk_on), .frequency_locked_loop_free_run(fll_run), .system_clock_enable(sys_en),
    .dc_servo_channel_enable(dcs), .insertion_current_threshold(ithr), .hookswitch_current_threshold(hthr),
    .current_detect_enable(det_en), .ins_state_out(ins_st), .hook_state_out(hook_st), .irq(irq));

  mic_accessory_model acc (.bias_ua(bias), .ins_thr(ithr), .hook_thr(hthr), .powered(det_en),
    .ins_upper(iau), .ins_lower(ial), .hook_upper(hau), .hook_lower(hal));

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string name, input [31:0] exp, input [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer, held until ready
  task apb(input [11:0] a, input w, input [31:0] d, output [31:0] r, output e);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++)
      @(posedge pclk);
    if (k == 20)
    begin
      chk("apb ready", 1, 0);
      wrap_up;
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input [11:0] a, input [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
    chk("write error", 0, e);
    // registered outputs follow the committed write one edge later
    @(posedge pclk);
  endtask

  task rd(input [11:0] a, input [31:0] exp, input string name);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(name, exp, r);
  endtask

  // wait for a state output, check latency window in cycles
  task wait_st(input bit hook, input bit val, input int lo, input int hi);
    int n;
    for (n = 1; n <= 300; n++)
    begin
      @(posedge pclk);
      if ((hook ? hook_st : ins_st) === val)
        break;
    end
    if (n > 300)
    begin
      chk("state wait", 1, 0);
      wrap_up;
    end
    chk("state delay", 1, n >= lo && n <= hi);
  endtask

  task t_reset_and_map;
    logic [31:0] r;
    logic        e;
    rd(`OFF_CONTROL, 32'h0, "control reset");
    rd(`OFF_IRQ_STATUS, 32'h0, "status reset");
    rd(`OFF_IRQ_ENABLE, 32'h0, "enable reset");
    apb(12'h020, 1'b0, 32'h0, r, e);
    chk("unmapped error", 1, e);
    for (int i = 0; i < 8; i++)
    begin
      wr(`OFF_CONTROL, (i << 4) | ((i & 3) << 2));
      chk("ins thr", i, ithr);
      chk("hook thr", i & 3, hthr);
      rd(`OFF_CONTROL, (i << 4) | ((i & 3) << 2), "control rw");
    end
    rd(`OFF_IRQ_CLEAR, 32'h0, "clear reads zero");
  endtask

  task t_insert;
    wr(`OFF_CONTROL, 32'h0000_0011);
    wr(`OFF_IRQ_ENABLE, 32'h0000_0003);
    bias <= 16'h0190;
    wait_st(0, 1, (DET - 1) * MEAS + 2, DET * MEAS + 2);
    rd(`OFF_STATE, 32'h5, "state reg");
    rd(`OFF_IRQ_STATUS, 32'h1, "insert status");
    chk("irq on", 1, irq);
    bias <= 16'h00F5;
    repeat (40) @(posedge pclk);
    chk("ins hysteresis", 1, ins_st);
    wr(`OFF_IRQ_CLEAR, 32'h0000_0001);
    rd(`OFF_IRQ_STATUS, 32'h0, "cleared status");
    chk("irq off", 0, irq);
  endtask

  task t_hook;
    bias <= 16'h02BC;
    repeat ((HOOK - 3) * MEAS) @(posedge pclk);
    bias <= 16'h0190;
    repeat (40) @(posedge pclk);
    chk("spike ignored", 0, hook_st);
    bias <= 16'h02BC;
    wait_st(1, 1, (HOOK - 1) * MEAS + 2, HOOK * MEAS + 2);
    bias <= 16'h01F4;
    repeat (60) @(posedge pclk);
    chk("hook hysteresis", 1, hook_st);
    rd(`OFF_IRQ_STATUS, 32'h2, "press status");
  endtask

  task t_release;
    wr(`OFF_IRQ_CLEAR, 32'h0000_0003);
    wr(`OFF_CONTROL, 32'h0000_0311);
    bias <= 16'h0190;
    wait_st(1, 0, (HOOK - 1) * MEAS + 2, HOOK * MEAS + 2);
    rd(`OFF_IRQ_STATUS, 32'h2, "release status");
    bias <= 16'h0000;
    wait_st(0, 0, (DET - 1) * MEAS + 2, DET * MEAS + 2);
    rd(`OFF_IRQ_STATUS, 32'h3, "removal status");
    wr(`OFF_IRQ_CLEAR, 32'h0000_0003);
  endtask

  task t_clock_loss;
    wr(`OFF_CONTROL, 32'h0000_0011);
    mclk_on <= 1'b0;
    bias    <= 16'h0190;
    repeat (100) @(posedge pclk);
    chk("no clock no state", 0, ins_st);
    rd(`OFF_STATE, 32'h0, "clock bad state");
    fll_run <= 1'b1;
    dcs     <= 4'h8;
    wait_st(0, 1, (DET - 1) * MEAS + 2, DET * MEAS + 2);
    rd(`OFF_IRQ_STATUS, 32'h1, "late status");
    wr(`OFF_IRQ_ENABLE, 32'h0000_0000);
    // irq is registered from the new enable one edge after it lands
    @(posedge pclk);
    chk("irq masked", 0, irq);
    rd(`OFF_IRQ_STATUS, 32'h1, "sticky status");
  endtask

  task t_disable;
    wr(`OFF_IRQ_CLEAR, 32'h0000_0003);
    wr(`OFF_IRQ_ENABLE, 32'h0000_0003);
    wr(`OFF_CONTROL, 32'h0000_0110);
    wait_st(0, 0, 1, 4);
    repeat (60) @(posedge pclk);
    rd(`OFF_IRQ_STATUS, 32'h0, "off no event");
    chk("off irq", 0, irq);
    chk("off enable", 0, det_en);
  endtask

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_and_map;
    t_insert;
    t_hook;
    t_release;
    t_clock_loss;
    t_disable;
    wrap_up;
  end
endmodule // tb
